// ===== sadma_channel.sv
// short-address dma channel with wishbone registers and a memory master
// assumes the memory answers each request with a one-cycle MEM_ACK
`timescale 1ns/1ps

module sadma_channel #(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                   CLK_SYS,
   input  wire logic                   RSTN,
   input  wire logic                   WB_CYC_I,
   input  wire logic                   WB_STB_I,
   input  wire logic                   WB_WE_I,
   input  wire logic [7:0]             WB_ADR_I,
   input  wire logic [3:0]             WB_SEL_I,
   input  wire logic [31:0]            WB_DAT_I,
   output logic      [31:0]            WB_DAT_O,
   output logic                        WB_ACK_O,
   input  wire logic [3:0]             REQ_TIMER,
   input  wire logic                   REQ_TX_EMPTY,
   input  wire logic                   REQ_RX_FULL,
   input  wire logic                   REQ_EXT,
   output sadma_pkg::mem_req_s         MEM_OUT,
   input  wire logic                   MEM_ACK,
   input  wire logic [15:0]            MEM_RDATA,
   output logic                        IRQ_REQ
);

   // whole state of the channel
   typedef struct packed {
      logic [23:0]              mem_addr;
      logic [7:0]               short_addr;
      logic [15:0]              count;
      sadma_pkg::control_s      ctrl;
      logic                     done;
      logic                     irq;
      logic                     pend;
      logic                     dir_rx;
      logic                     ext_s1;
      logic                     ext_s2;
      logic                     req_prev;
      sadma_pkg::seq_e          seq;
      sadma_pkg::mem_req_s      mem;
      logic [1:0][15:0]         buf_data;
      logic                     buf_wp;
      logic                     buf_rp;
      logic [1:0]               buf_cnt;
      logic                     wb_ack;
      logic [31:0]              wb_dat;
   } state_s;

   localparam state_s RST_STATE = '{
      sadma_pkg::RST_MEM_ADDR, sadma_pkg::RST_SHORT_ADDR,
      sadma_pkg::RST_COUNT, sadma_pkg::RST_CONTROL,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
      sadma_pkg::ST_WAIT, sadma_pkg::RST_MEM_REQ,
      32'h0, 1'b0, 1'b0, 2'h0, 1'b0, 32'h0};

   localparam logic [1:0] BUF_FULL = 2'(BUF_DEPTH);

   state_s s_r;
   state_s s_nxt;

   logic        wb_hit;
   logic        wb_wr;
   logic        req_now;
   logic        req_edge;
   logic        in_ready;
   logic        out_valid;
   logic        src_rx;
   logic [23:0] short_full;
   logic [23:0] step;
   logic [15:0] cnt_dec;
   logic [31:0] merged;

   // byte-lane merge of a wishbone write into an old value
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // next-state logic of the whole channel
   always_comb begin
      s_nxt = s_r;
      merged = 32'h0;

      // request sources, external pin through two flops
      s_nxt.ext_s1 = REQ_EXT;
      s_nxt.ext_s2 = s_r.ext_s1;
      unique case (s_r.ctrl.source_select)
         sadma_pkg::SRC_TIMER0:   req_now = REQ_TIMER[0];
         sadma_pkg::SRC_TIMER1:   req_now = REQ_TIMER[1];
         sadma_pkg::SRC_TIMER2:   req_now = REQ_TIMER[2];
         sadma_pkg::SRC_TIMER3:   req_now = REQ_TIMER[3];
         sadma_pkg::SRC_TX_EMPTY: req_now = REQ_TX_EMPTY;
         sadma_pkg::SRC_RX_FULL:  req_now = REQ_RX_FULL;
         sadma_pkg::SRC_EXTERNAL: req_now = s_r.ext_s2;
         default:                 req_now = 1'b0;
      endcase
      s_nxt.req_prev = req_now;
      req_edge = req_now & ~s_r.req_prev;

      // derived addressing
      src_rx = (s_r.ctrl.source_select == sadma_pkg::SRC_RX_FULL);
      short_full = {sadma_pkg::SHORT_PAGE, s_r.short_addr};
      step = s_r.ctrl.transfer_size_select
           ? sadma_pkg::STEP_WORD : sadma_pkg::STEP_BYTE;
      cnt_dec = s_r.count - 16'h0001;   // zero wraps to a full run

      // two-entry data buffer flags
      in_ready  = (s_r.buf_cnt != BUF_FULL);
      out_valid = (s_r.buf_cnt != 2'h0);

      // wishbone slave, answer one cycle after the strobe
      wb_hit = WB_CYC_I & WB_STB_I & ~s_r.wb_ack;
      wb_wr  = wb_hit & WB_WE_I;
      s_nxt.wb_ack = wb_hit;
      if (wb_hit) begin
         unique case (WB_ADR_I)
            sadma_pkg::OFS_MEM_ADDR:   s_nxt.wb_dat = {8'h00, s_r.mem_addr};
            sadma_pkg::OFS_SHORT_ADDR: s_nxt.wb_dat = {24'h0, s_r.short_addr};
            sadma_pkg::OFS_COUNT:      s_nxt.wb_dat = {16'h0, s_r.count};
            sadma_pkg::OFS_CONTROL:    s_nxt.wb_dat = {24'h0, s_r.ctrl};
            sadma_pkg::OFS_STATUS: begin
               s_nxt.wb_dat = 32'h0;
               s_nxt.wb_dat[sadma_pkg::STAT_DONE_BIT] = s_r.done;
               s_nxt.wb_dat[sadma_pkg::STAT_BUSY_BIT] =
                  (s_r.seq != sadma_pkg::ST_WAIT);
            end
            default:                   s_nxt.wb_dat = 32'h0;
         endcase
      end

      // software register writes, setup before enable
      if (wb_wr) begin
         unique case (WB_ADR_I)
            sadma_pkg::OFS_MEM_ADDR: begin
               merged = lane_merge({8'h00, s_r.mem_addr}, WB_DAT_I, WB_SEL_I);
               s_nxt.mem_addr = merged[23:0];
            end
            sadma_pkg::OFS_SHORT_ADDR: begin
               merged = lane_merge({24'h0, s_r.short_addr}, WB_DAT_I,
                                   WB_SEL_I);
               s_nxt.short_addr = merged[7:0];
            end
            sadma_pkg::OFS_COUNT: begin
               merged = lane_merge({16'h0, s_r.count}, WB_DAT_I, WB_SEL_I);
               s_nxt.count = merged[15:0];
            end
            sadma_pkg::OFS_CONTROL: begin
               // mode picked for this channel alone
               merged = lane_merge({24'h0, s_r.ctrl}, WB_DAT_I, WB_SEL_I);
               s_nxt.ctrl = sadma_pkg::control_s'(merged[7:0]);
            end
            sadma_pkg::OFS_STATUS: begin
               if (WB_SEL_I[0] & WB_DAT_I[sadma_pkg::STAT_DONE_BIT]) begin
                  s_nxt.done = 1'b0;            // write one to clear
               end
            end
            default: begin
            end
         endcase
      end

      // latch activation only while enabled
      if (s_r.ctrl.channel_run_enable & req_edge) begin
         s_nxt.pend = 1'b1;
      end
      if (!s_r.ctrl.channel_run_enable) begin
         s_nxt.pend = 1'b0;
      end

      // transfer sequencer
      unique case (s_r.seq)
         sadma_pkg::ST_WAIT: begin
            if (s_r.ctrl.channel_run_enable & s_r.pend & in_ready) begin
               // one unit per request in either mode
               s_nxt.pend = req_edge;
               s_nxt.dir_rx = src_rx;
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.we = 1'b0;
               s_nxt.mem.word = s_r.ctrl.transfer_size_select;
               s_nxt.mem.addr = src_rx ? short_full
                                       : s_r.mem_addr;
               s_nxt.seq = sadma_pkg::ST_READ;
            end
         end
         sadma_pkg::ST_READ: begin
            if (MEM_ACK) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.buf_data[s_r.buf_wp] = MEM_RDATA;
               s_nxt.buf_wp = ~s_r.buf_wp;
               s_nxt.buf_cnt = s_r.buf_cnt + 2'h1;
               s_nxt.seq = sadma_pkg::ST_WRITE;
            end
         end
         sadma_pkg::ST_WRITE: begin
            if (!s_r.mem.req & out_valid) begin
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.we = 1'b1;
               s_nxt.mem.addr = s_r.dir_rx ? s_r.mem_addr
                                           : short_full;
               s_nxt.mem.wdata = s_r.buf_data[s_r.buf_rp];
            end else if (s_r.mem.req & MEM_ACK) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.buf_rp = ~s_r.buf_rp;
               s_nxt.buf_cnt = s_r.buf_cnt - 2'h1;
               // count and address move in one step
               s_nxt.count = cnt_dec;
               if (s_r.ctrl.mode_select == sadma_pkg::MODE_IO) begin
                  s_nxt.mem_addr = s_r.ctrl.address_step_direction
                                 ? s_r.mem_addr - step
                                 : s_r.mem_addr + step;
               end
               // idle mode leaves mem_addr as is
               if (cnt_dec == 16'h0000) begin
                  s_nxt.ctrl.channel_run_enable = 1'b0;
                  s_nxt.pend = 1'b0;
                  s_nxt.done = 1'b1;                      // set wins over clear
               end
               s_nxt.seq = sadma_pkg::ST_WAIT;
            end
         end
         default: begin
            s_nxt.seq = sadma_pkg::ST_WAIT;
            s_nxt.mem.req = 1'b0;
         end
      endcase

      // completion request: io mode gated, idle mode always
      s_nxt.irq = s_nxt.done &
                  (s_nxt.ctrl.completion_irq_enable |
                   (s_nxt.ctrl.mode_select == sadma_pkg::MODE_IDLE));
   end

   // state register
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         s_r <= RST_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   assign WB_DAT_O = s_r.wb_dat;
   assign WB_ACK_O = s_r.wb_ack;
   assign MEM_OUT  = s_r.mem;
   assign IRQ_REQ  = s_r.irq;

endmodule

// ===== sadma_mem_model.sv
// memory model on the channel's master side
// answers after wait_n cycles; read data is made from the address
`timescale 1ns/1ps
module sadma_mem_model (
   input  wire logic                CLK_SYS,
   input  wire logic                RSTN,
   input  wire sadma_pkg::mem_req_s MEM_IN,
   input  wire logic [3:0]          wait_n,
   output logic                     mem_ack,
   output logic [15:0]              mem_rdata,
   output logic [23:0]              raddr,
   output logic [23:0]              waddr,
   output logic [15:0]              wdata,
   output int                       writes
);
   logic [3:0] cnt;
   // one ack per request, data inverted once released
   always @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         mem_ack <= 1'b0;
         cnt <= 4'h0;
         writes <= 0;
         mem_rdata <= 16'h0000;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= 4'h0;
      end else if (MEM_IN.req && cnt == wait_n) begin
         mem_ack <= 1'b1;
         if (MEM_IN.we) begin
            waddr <= MEM_IN.addr;
            wdata <= MEM_IN.wdata;
            writes <= writes + 1;
         end else begin
            raddr <= MEM_IN.addr;
            mem_rdata <= {MEM_IN.addr[7:0], ~MEM_IN.addr[7:0]};
         end
      end else if (MEM_IN.req)
         cnt <= cnt + 4'h1;
   end
endmodule

// ===== sadma_pkg.sv
// constants, field layouts and carrier types of the short-address channel
// assumes a 32-bit classic wishbone register bus and a 200 MHz system clock
package sadma_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_MEM_ADDR   = 8'h00;
   localparam logic [7:0] OFS_SHORT_ADDR = 8'h04;
   localparam logic [7:0] OFS_COUNT      = 8'h08;
   localparam logic [7:0] OFS_CONTROL    = 8'h0C;
   localparam logic [7:0] OFS_STATUS     = 8'h10;

   // reset values
   localparam logic [23:0] RST_MEM_ADDR   = 24'h000000;
   localparam logic [7:0]  RST_SHORT_ADDR = 8'h00;
   localparam logic [15:0] RST_COUNT      = 16'h0000;

   // short-side upper address bits
   localparam logic [15:0] SHORT_PAGE = 16'hFFFF;

   // status field positions
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;

   // activation source codes
   localparam logic [2:0] SRC_TIMER0  = 3'h0;
   localparam logic [2:0] SRC_TIMER1  = 3'h1;
   localparam logic [2:0] SRC_TIMER2  = 3'h2;
   localparam logic [2:0] SRC_TIMER3  = 3'h3;
   localparam logic [2:0] SRC_TX_EMPTY = 3'h4;
   localparam logic [2:0] SRC_RX_FULL = 3'h5;
   localparam logic [2:0] SRC_EXTERNAL = 3'h6;

   // operating modes
   localparam logic MODE_IO   = 1'b0;
   localparam logic MODE_IDLE = 1'b1;

   // address steps
   localparam logic [23:0] STEP_BYTE = 24'h000001;
   localparam logic [23:0] STEP_WORD = 24'h000002;

   // transfer_control_reg layout, low bit is channel_run_enable
   typedef struct packed {
      logic [2:0] source_select;
      logic       mode_select;
      logic       address_step_direction;
      logic       transfer_size_select;
      logic       completion_irq_enable;
      logic       channel_run_enable;
   } control_s;

   localparam control_s RST_CONTROL = '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

   // memory bus request carrier
   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [23:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

   localparam mem_req_s RST_MEM_REQ = '{1'b0, 1'b0, 1'b0, 24'h0, 16'h0};

   // sequencer states
   typedef enum logic [2:0] {
      ST_WAIT  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } seq_e;

endpackage

// ===== sadma_props.sv
// assertions on the channel's bus, memory and irq ports
// bound to every sadma_channel, one clock domain
`timescale 1ns/1ps
module sadma_props (
   input wire logic                CLK_SYS,
   input wire logic                RSTN,
   input wire logic                WB_CYC_I,
   input wire logic                WB_STB_I,
   input wire logic                WB_ACK_O,
   input wire sadma_pkg::mem_req_s MEM_OUT,
   input wire logic                MEM_ACK,
   input wire logic [15:0]         MEM_RDATA,
   input wire logic                IRQ_REQ
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   logic rd_ack;
   logic wr_ack;
   // answered read and write units
   assign rd_ack = MEM_OUT.req && !MEM_OUT.we && MEM_ACK;
   assign wr_ack = MEM_OUT.req && MEM_OUT.we && MEM_ACK;
   property p_ack_next;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("register access not answered");
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("bus ack longer than one cycle");
   property p_req_hold;
      MEM_OUT.req && !MEM_ACK |=> MEM_OUT.req && $stable(MEM_OUT);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("memory request changed before ack");
   property p_req_drop;
      MEM_OUT.req && MEM_ACK |=> !MEM_OUT.req;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("memory request held after ack");
   property p_rd_wr;
      rd_ack |=> !MEM_OUT.req ##1 (MEM_OUT.req && MEM_OUT.we);
   endproperty
   a_rd_wr: assert property (p_rd_wr)
      else $error("read not followed by its write");
   property p_wr_cause;
      $rose(MEM_OUT.req) && MEM_OUT.we |-> $past(rd_ack, 2);
   endproperty
   a_wr_cause: assert property (p_wr_cause)
      else $error("write without a read before it");
   property p_data;
      rd_ack && MEM_OUT.word ##2 1'b1 |->
         MEM_OUT.wdata == $past(MEM_RDATA, 2);
   endproperty
   a_data: assert property (p_data)
      else $error("written word differs from read word");
   property p_size;
      rd_ack ##2 1'b1 |-> MEM_OUT.word == $past(MEM_OUT.word, 2);
   endproperty
   a_size: assert property (p_size)
      else $error("unit size changed within a transfer");
   property p_irq;
      $rose(IRQ_REQ) |-> $past(wr_ack);
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq raised without a finished write");
endmodule

bind sadma_channel sadma_props u_sadma_props (.CLK_SYS, .RSTN, .WB_CYC_I,
   .WB_STB_I, .WB_ACK_O, .MEM_OUT, .MEM_ACK, .MEM_RDATA, .IRQ_REQ);

// ===== sadma_tb.sv
// self-checking bench for the short-address channel
// drives wishbone and request inputs, memory model on the far side
`timescale 1ns/1ps
module testbench;
   logic                CLK_SYS, RSTN, cyc, stb, we, ack, irq, m_ack;
   logic                tx, rx, ext;
   logic [7:0]          adr;
   logic [3:0]          sel, tmr, wait_n;
   logic [31:0]         dati, dato, rd;
   logic [15:0]         m_rdata, m_wdata;
   logic [23:0]         m_raddr, m_waddr;
   sadma_pkg::mem_req_s mem;
   int                  writes, fails, n_compared, cycles;
   sadma_channel u_sadma_channel (.CLK_SYS, .RSTN, .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .REQ_TIMER(tmr),
      .REQ_TX_EMPTY(tx), .REQ_RX_FULL(rx), .REQ_EXT(ext), .MEM_OUT(mem),
      .MEM_ACK(m_ack), .MEM_RDATA(m_rdata), .IRQ_REQ(irq));
   sadma_mem_model u_sadma_mem_model (.CLK_SYS, .RSTN, .MEM_IN(mem),
      .wait_n, .mem_ack(m_ack), .mem_rdata(m_rdata), .raddr(m_raddr),
      .waddr(m_waddr), .wdata(m_wdata), .writes);
   // clock and hang guard
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         $display("mismatch timeout expected done seen %0d cycles", cycles);
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("fails %0d n_compared %0d", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic wishbone cycle, held until ack
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge CLK_SYS);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dati <= d;
      sel <= 4'hF;
      do begin
         @(posedge CLK_SYS);
      end while (ack !== 1'b1);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic pulse(int s);
      @(posedge CLK_SYS);
      case (s)
         4: tx <= 1'b1;
         5: rx <= 1'b1;
         6: ext <= 1'b1;
         default: tmr[s] <= 1'b1;
      endcase
      @(posedge CLK_SYS);
      {tmr, tx, rx, ext} <= 7'h00;
   endtask
   task automatic wait_w(int n);
      for (int k = 0; k < 200 && writes < n; k++)
         @(posedge CLK_SYS);
      repeat (3) @(posedge CLK_SYS);
   endtask
   // reset values, read-back widths, unmapped place
   task automatic t_regs();
      logic [31:0] m [6] = '{32'hFFFFFF, 32'hFF, 32'hFFFF, 0, 0, 0};
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk("reset", 32'h0, rd);
         if (i != 3 && i != 4) begin
            wb(1'b1, 8'(i * 4), 32'hFFFFFFFF);
            wb(1'b0, 8'(i * 4), 32'h0);
            chk("width", m[i], rd);
         end
      end
   endtask
   // two units from source s; size, step, mode and irq vary with s
   task automatic t_src(int s);
      logic wd, dn, idle, ie;
      logic [23:0] ma, mx, mf, st, sa, ra;
      logic [31:0] ctl;
      int w0;
      wd = s[0];
      dn = s[1];
      idle = s >= 4;
      ie = s != 1 && s != 5;
      wait_n <= wd ? 4'h3 : 4'h0;
      st = wd ? 24'h2 : 24'h1;
      ma = 24'h123450 + 24'(s * 16);
      sa = {16'hFFFF, 8'(8'h80 + s)};
      mx = idle ? ma : dn ? ma - st : ma + st;
      mf = idle ? ma : dn ? mx - st : mx + st;
      ctl = {24'h0, 3'(s), idle, dn, wd, ie, 1'b1};
      wb(1'b1, sadma_pkg::OFS_MEM_ADDR, 32'(ma));
      wb(1'b1, sadma_pkg::OFS_SHORT_ADDR, 32'(sa[7:0]));
      wb(1'b1, sadma_pkg::OFS_COUNT, 32'h2);
      wb(1'b1, sadma_pkg::OFS_CONTROL, ctl);
      w0 = writes;
      pulse(s);
      wait_w(w0 + 1);
      pulse(s);
      wait_w(w0 + 2);
      chk("units", 32'(w0 + 2), 32'(writes));
      wb(1'b0, sadma_pkg::OFS_COUNT, 32'h0);
      chk("count", 32'h0, rd);
      wb(1'b0, sadma_pkg::OFS_CONTROL, 32'h0);
      chk("control", ctl & 32'hFFFFFFFE, rd);
      wb(1'b0, sadma_pkg::OFS_MEM_ADDR, 32'h0);
      chk("mem addr", 32'(mf), rd);
      wb(1'b0, sadma_pkg::OFS_SHORT_ADDR, 32'h0);
      chk("short", 32'(sa[7:0]), rd);
      ra = s == 5 ? sa : mx;
      chk("read addr", 32'(ra), 32'(m_raddr));
      chk("write addr", 32'(s == 5 ? mx : sa), 32'(m_waddr));
      chk("data", 32'({ra[7:0], ~ra[7:0]} & (wd ? 16'hFFFF : 16'h00FF)),
         32'(m_wdata & (wd ? 16'hFFFF : 16'h00FF)));
      chk("irq", 32'(ie | idle), 32'(irq));
      wb(1'b0, sadma_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'h1, rd);
      wb(1'b1, sadma_pkg::OFS_STATUS, 32'h1);
      @(posedge CLK_SYS);
      chk("irq clear", 32'h0, 32'(irq));
   endtask
   // count zero runs on; disabled channel ignores requests
   task automatic t_zero();
      int w0;
      wb(1'b1, sadma_pkg::OFS_COUNT, 32'h0);
      wb(1'b1, sadma_pkg::OFS_CONTROL, 32'h03);
      w0 = writes;
      pulse(0);
      wait_w(w0 + 1);
      wb(1'b0, sadma_pkg::OFS_COUNT, 32'h0);
      chk("count wrap", 32'hFFFF, rd);
      wb(1'b0, sadma_pkg::OFS_CONTROL, 32'h0);
      chk("still on", 32'h03, rd);
      wb(1'b1, sadma_pkg::OFS_CONTROL, 32'h0);
      pulse(0);
      repeat (20) @(posedge CLK_SYS);
      chk("off", 32'(w0 + 1), 32'(writes));
      wb(1'b1, sadma_pkg::OFS_CONTROL, 32'hE1);
      pulse(0);
      repeat (20) @(posedge CLK_SYS);
      chk("no source", 32'(w0 + 1), 32'(writes));
      wb(1'b1, sadma_pkg::OFS_CONTROL, 32'h0);
   endtask
   initial begin
      {cyc, stb, we, tx, rx, ext} = 6'h00;
      adr = 8'h00;
      sel = 4'h0;
      dati = 32'h0;
      tmr = 4'h0;
      wait_n = 4'h0;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      RSTN = 1'b0;
      repeat (12) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      t_regs();
      for (int s = 0; s < 7; s++)
         t_src(s);
      t_zero();
      print_verdict();
   end
endmodule
